// file: inc/dll_cfg_pkg.sv
// Register map, field layout, reset values and timing of the DLL phase controller block
`default_nettype none
package dll_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Serial port framing
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [4:0] SPI_ADDR_LAST_BIT = 5'h07;
    localparam logic [4:0] SPI_DATA_LAST_BIT = 5'h0f;
    localparam logic [4:0] SPI_FRAME_BITS    = 5'h10;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [ADDR_W-1:0] CLK_POS_COMMON_MODE_OFFSET = 7'h22;
    localparam logic [ADDR_W-1:0] CLK_NEG_COMMON_MODE_OFFSET = 7'h23;
    localparam logic [ADDR_W-1:0] PHASE_DETECTOR_CONTROL     = 7'h24;
    localparam logic [ADDR_W-1:0] DUTY_CYCLE_CONTROL         = 7'h25;
    localparam logic [ADDR_W-1:0] DELAY_CONTROLLER_MODE      = 7'h26;
    localparam logic [ADDR_W-1:0] DELAY_SEARCH_CONFIG        = 7'h27;
    localparam logic [ADDR_W-1:0] DELAY_VALUE_UPPER          = 7'h28;
    localparam logic [ADDR_W-1:0] DELAY_GUARD_CONFIG         = 7'h29;
    localparam logic [ADDR_W-1:0] DELAY_LOCK_STATUS          = 7'h2a;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int OFFSET_DIR_BIT    = 4;
    localparam int COMPARATOR_BIT    = 5;
    localparam int PHASE_AUTO_BIT    = 4;
    localparam int DUTY_AUTO_BIT     = 7;
    localparam int SLOPE_BIT         = 6;
    localparam int MODE_LSB          = 4;
    localparam int READBACK_BIT      = 3;
    localparam int GAIN_LSB          = 1;
    localparam int ENABLE_BIT        = 0;
    localparam int DELAY_LSB_BIT     = 7;
    localparam int SEARCH_DIR_LSB    = 5;
    localparam int LOST_BIT          = 1;
    localparam int LOCKED_BIT        = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] MODE_REG_RST  = 8'h42;
    localparam logic [7:0] GUARD_REG_RST = 8'h0b;
    localparam logic [7:0] ZERO_RST      = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Delay line limits and loop figures
    localparam logic [8:0] DELAY_MAX       = 9'h1b0;
    localparam logic [4:0] TARGET_PHASE_MAX = 5'h10;
    localparam logic [4:0] LOST_LIMIT      = 5'h04;
    localparam int CLK_MHZ         = 125;
    localparam int SETTLE_NS       = 64;
    localparam int SETTLE_CYCLES   = (SETTLE_NS * CLK_MHZ + 999) / 1000;

    ////////////////////////////////////////////////////////////////////////////
    // Encodings
    typedef enum logic [1:0] {
        MODE_SEARCH_TRACK = 2'b00,
        MODE_SEARCH_ONLY  = 2'b01,
        MODE_TRACK_ONLY   = 2'b10
    } dll_mode_t;

    typedef enum logic [1:0] {
        DIR_DOWN    = 2'b00,
        DIR_UP      = 2'b01,
        DIR_DOWN_UP = 2'b10
    } search_dir_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SEARCH = 3'b001,
        ST_TRACK  = 3'b010,
        ST_HOLD   = 3'b011,
        ST_FAIL   = 3'b100
    } dll_state_t;

endpackage
`default_nettype wire

// file: rtl/dll_phase_controller_config.sv
// DLL phase controller configuration, search/track engine and status readback
//
// Notes on behaviour
// - Four-bit offset magnitude per clock input
// - Positive direction bit zero lowers common mode
// - Comparator boost and auto enable bits
// - Duty correction enable at bit seven
// - Slope bit picks lock slope, resets one
// - Mode: search+track, search only, track only
// - Readback bit selects live delay on reads when enabled
// - Tracking gain in bits two to one
// - Enable bit zero, resets disabled
// - Delay LSB bit seven, upper eight next
// - Search direction down, up, down then up
// - Five-bit target phase, maximum sixteen
// - Disabled: setting drives delay, max 432
// - Enabled: setting is search start point
// - Readback shows written or live delay
// - Read-only locked and lost-lock status bits
// - Guard band keeps first search pass off line ends
`timescale 1ns/1ns
`default_nettype none
module dll_phase_controller_config (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Serial configuration port
    input  wire logic       spi_cs_n,
    input  wire logic       spi_sclk,
    input  wire logic       spi_mosi,
    output logic            spi_miso,
    output logic            spi_miso_oe,
    // Phase detector
    input  wire logic [4:0] phase_measure,
    input  wire logic       phase_slope_pos,
    // Clock input common mode controls
    output logic [3:0]      pos_offset_magnitude,
    output logic            pos_offset_dir,
    output logic [3:0]      neg_offset_magnitude,
    output logic            neg_offset_dir,
    // Analog enables
    output logic            comparator_boost,
    output logic            phase_detect_auto_enable,
    output logic            duty_correction_enable,
    // Delay line and status
    output logic [8:0]      delay_line_value,
    output logic            dll_locked,
    output logic            dll_lock_lost
);

    logic [6:0] reg_addr;
    logic       reg_wr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;

    spi_reg_port u_spi (
        .clk         (clk),
        .reset_n     (reset_n),
        .spi_cs_n    (spi_cs_n),
        .spi_sclk    (spi_sclk),
        .spi_mosi    (spi_mosi),
        .spi_miso    (spi_miso),
        .spi_miso_oe (spi_miso_oe),
        .reg_addr    (reg_addr),
        .reg_wr      (reg_wr),
        .reg_wdata   (reg_wdata),
        .reg_rdata   (reg_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [8:0] clamp_delay(input logic [8:0] d);
        clamp_delay = (d > dll_cfg_pkg::DELAY_MAX) ? dll_cfg_pkg::DELAY_MAX : d;
    endfunction

    // Saturating step inside [lo, hi]
    function automatic logic [8:0] step_delay(input logic [8:0] d, input logic up,
                                              input logic [8:0] step,
                                              input logic [8:0] lo, input logic [8:0] hi);
        logic [9:0] sum;
        sum = 10'h000;
        if (up) begin
            sum        = {1'b0, d} + {1'b0, step};
            step_delay = (sum > {1'b0, hi}) ? hi : sum[8:0];
        end else begin
            step_delay = (d < lo + step) ? lo : d - step;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [4:0] pos_cfg, next_pos_cfg;
    logic [4:0] neg_cfg, next_neg_cfg;
    logic [1:0] pd_cfg, next_pd_cfg;
    logic       duty_cfg, next_duty_cfg;
    logic [7:0] mode_reg, next_mode_reg;
    logic [7:0] search_reg, next_search_reg;
    logic [7:0] upper_reg, next_upper_reg;
    logic [7:0] guard_reg, next_guard_reg;

    always_comb begin
        next_pos_cfg    = pos_cfg;
        next_neg_cfg    = neg_cfg;
        next_pd_cfg     = pd_cfg;
        next_duty_cfg   = duty_cfg;
        next_mode_reg   = mode_reg;
        next_search_reg = search_reg;
        next_upper_reg  = upper_reg;
        next_guard_reg  = guard_reg;
        if (reg_wr) begin
            case (reg_addr)
                dll_cfg_pkg::CLK_POS_COMMON_MODE_OFFSET: next_pos_cfg    = reg_wdata[4:0];
                dll_cfg_pkg::CLK_NEG_COMMON_MODE_OFFSET: next_neg_cfg    = reg_wdata[4:0];
                dll_cfg_pkg::PHASE_DETECTOR_CONTROL: begin
                    next_pd_cfg = {reg_wdata[dll_cfg_pkg::COMPARATOR_BIT],
                                   reg_wdata[dll_cfg_pkg::PHASE_AUTO_BIT]};
                end
                dll_cfg_pkg::DUTY_CYCLE_CONTROL: next_duty_cfg = reg_wdata[dll_cfg_pkg::DUTY_AUTO_BIT];
                dll_cfg_pkg::DELAY_CONTROLLER_MODE: next_mode_reg  = reg_wdata & 8'h7f;
                dll_cfg_pkg::DELAY_SEARCH_CONFIG:   next_search_reg = reg_wdata;
                dll_cfg_pkg::DELAY_VALUE_UPPER:     next_upper_reg  = reg_wdata;
                dll_cfg_pkg::DELAY_GUARD_CONFIG:    next_guard_reg  = reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pos_cfg    <= 5'h00;
            neg_cfg    <= 5'h00;
            pd_cfg     <= 2'h0;
            duty_cfg   <= 1'b0;
            mode_reg   <= dll_cfg_pkg::MODE_REG_RST;
            search_reg <= dll_cfg_pkg::ZERO_RST;
            upper_reg  <= dll_cfg_pkg::ZERO_RST;
            guard_reg  <= dll_cfg_pkg::GUARD_REG_RST;
        end else begin
            pos_cfg    <= next_pos_cfg;
            neg_cfg    <= next_neg_cfg;
            pd_cfg     <= next_pd_cfg;
            duty_cfg   <= next_duty_cfg;
            mode_reg   <= next_mode_reg;
            search_reg <= next_search_reg;
            upper_reg  <= next_upper_reg;
            guard_reg  <= next_guard_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field decode
    logic        ctrl_en;
    logic        readback;
    logic        slope_pos;
    logic [1:0]  mode;
    logic [1:0]  gain;
    logic [1:0]  sdir;
    logic [4:0]  target;
    logic [8:0]  delay_setting;
    logic [8:0]  guard;
    logic [8:0]  gain_step;

    always_comb begin
        ctrl_en       = mode_reg[dll_cfg_pkg::ENABLE_BIT];
        readback      = mode_reg[dll_cfg_pkg::READBACK_BIT];
        slope_pos     = mode_reg[dll_cfg_pkg::SLOPE_BIT];
        mode          = mode_reg[dll_cfg_pkg::MODE_LSB +: 2];
        gain          = mode_reg[dll_cfg_pkg::GAIN_LSB +: 2];
        sdir          = search_reg[dll_cfg_pkg::SEARCH_DIR_LSB +: 2];
        // Targets above the maximum would never match; hold them at it
        target        = (search_reg[4:0] > dll_cfg_pkg::TARGET_PHASE_MAX) ?
                        dll_cfg_pkg::TARGET_PHASE_MAX : search_reg[4:0];
        delay_setting = clamp_delay({upper_reg, search_reg[dll_cfg_pkg::DELAY_LSB_BIT]});
        guard         = {4'h0, guard_reg[4:0]};
        gain_step     = 9'h001 << gain;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Search and track engine
    dll_cfg_pkg::dll_state_t state, next_state;
    logic [8:0] delay, next_delay;
    logic [3:0] settle, next_settle;
    logic       locked, next_locked;
    logic       lost, next_lost;
    logic       turned, next_turned;
    logic       guard_on, next_guard_on;
    logic       match;
    logic       going_up;
    logic       at_end;
    logic [8:0] lo;
    logic [8:0] hi;
    logic [4:0] err;
    logic       settled;

    always_comb begin
        match    = (phase_measure == target) && (phase_slope_pos == slope_pos);
        going_up = (sdir == dll_cfg_pkg::DIR_UP) ||
                   (sdir == dll_cfg_pkg::DIR_DOWN_UP && turned);
        lo       = guard_on ? guard : 9'h000;
        hi       = guard_on ? dll_cfg_pkg::DELAY_MAX - guard : dll_cfg_pkg::DELAY_MAX;
        at_end   = going_up ? (delay >= hi) : (delay <= lo);
        err      = (phase_measure > target) ? phase_measure - target : target - phase_measure;
        settled  = (settle == 4'(dll_cfg_pkg::SETTLE_CYCLES - 1));
        next_state    = state;
        next_delay    = delay;
        next_settle   = settled ? 4'h0 : settle + 4'h1;
        next_locked   = locked;
        next_lost     = lost;
        next_turned   = turned;
        next_guard_on = guard_on;
        if (!ctrl_en) begin
            // Disabled: the setting drives the line directly
            next_state  = dll_cfg_pkg::ST_IDLE;
            next_delay  = delay_setting;
            next_settle = 4'h0;
            next_locked = 1'b0;
            next_lost   = 1'b0;
        end else begin
            case (state)
                dll_cfg_pkg::ST_IDLE: begin
                    next_delay    = delay_setting;
                    next_settle   = 4'h0;
                    next_turned   = 1'b0;
                    next_guard_on = 1'b1;
                    next_state    = (mode == dll_cfg_pkg::MODE_TRACK_ONLY) ?
                                    dll_cfg_pkg::ST_TRACK : dll_cfg_pkg::ST_SEARCH;
                end
                dll_cfg_pkg::ST_SEARCH: begin
                    if (settled) begin
                        if (match) begin
                            next_locked = 1'b1;
                            next_state  = (mode == dll_cfg_pkg::MODE_SEARCH_ONLY) ?
                                          dll_cfg_pkg::ST_HOLD : dll_cfg_pkg::ST_TRACK;
                        end else if (!at_end) begin
                            next_delay = step_delay(delay, going_up, 9'h001, lo, hi);
                        end else if (sdir == dll_cfg_pkg::DIR_DOWN_UP && !turned) begin
                            next_turned = 1'b1;
                            next_delay  = delay_setting;
                        end else if (guard_on) begin
                            // Nothing inside the band; retry over the whole line
                            next_guard_on = 1'b0;
                            next_turned   = 1'b0;
                            next_delay    = delay_setting;
                        end else begin
                            next_state = dll_cfg_pkg::ST_FAIL;
                            next_lost  = 1'b1;
                        end
                    end
                end
                dll_cfg_pkg::ST_TRACK: begin
                    if (settled) begin
                        if (match) begin
                            next_locked = 1'b1;
                        end else if (err > dll_cfg_pkg::LOST_LIMIT) begin
                            next_locked = 1'b0;
                            next_lost   = 1'b1;
                            if (mode == dll_cfg_pkg::MODE_SEARCH_TRACK) begin
                                next_state = dll_cfg_pkg::ST_IDLE;
                            end
                        end else begin
                            // Phase rises with delay on a positive slope
                            next_delay = step_delay(delay, (phase_measure < target) == slope_pos,
                                                    gain_step, 9'h000, dll_cfg_pkg::DELAY_MAX);
                        end
                    end
                end
                dll_cfg_pkg::ST_HOLD: ;
                dll_cfg_pkg::ST_FAIL: ;
                default: next_state = dll_cfg_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state    <= dll_cfg_pkg::ST_IDLE;
            delay    <= 9'h000;
            settle   <= 4'h0;
            locked   <= 1'b0;
            lost     <= 1'b0;
            turned   <= 1'b0;
            guard_on <= 1'b1;
        end else begin
            state    <= next_state;
            delay    <= next_delay;
            settle   <= next_settle;
            locked   <= next_locked;
            lost     <= next_lost;
            turned   <= next_turned;
            guard_on <= next_guard_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; addressed one cycle before the port samples it
    logic [8:0] delay_read;

    always_comb begin
        // Written value, not the clamped one, so software sees what it stored
        delay_read = (readback && ctrl_en) ? delay :
                     {upper_reg, search_reg[dll_cfg_pkg::DELAY_LSB_BIT]};
        case (reg_addr)
            dll_cfg_pkg::CLK_POS_COMMON_MODE_OFFSET: reg_rdata = {3'h0, pos_cfg};
            dll_cfg_pkg::CLK_NEG_COMMON_MODE_OFFSET: reg_rdata = {3'h0, neg_cfg};
            dll_cfg_pkg::PHASE_DETECTOR_CONTROL:     reg_rdata = {2'h0, pd_cfg, 4'h0};
            dll_cfg_pkg::DUTY_CYCLE_CONTROL:         reg_rdata = {duty_cfg, 7'h00};
            dll_cfg_pkg::DELAY_CONTROLLER_MODE:      reg_rdata = mode_reg;
            dll_cfg_pkg::DELAY_SEARCH_CONFIG:        reg_rdata = {delay_read[0], search_reg[6:0]};
            dll_cfg_pkg::DELAY_VALUE_UPPER:          reg_rdata = delay_read[8:1];
            dll_cfg_pkg::DELAY_GUARD_CONFIG:         reg_rdata = guard_reg;
            dll_cfg_pkg::DELAY_LOCK_STATUS:          reg_rdata = {6'h00, lost, locked};
            default:                                 reg_rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign pos_offset_magnitude     = pos_cfg[3:0];
    assign pos_offset_dir           = pos_cfg[dll_cfg_pkg::OFFSET_DIR_BIT];
    assign neg_offset_magnitude     = neg_cfg[3:0];
    assign neg_offset_dir           = neg_cfg[dll_cfg_pkg::OFFSET_DIR_BIT];
    assign comparator_boost         = pd_cfg[1];
    assign phase_detect_auto_enable = pd_cfg[0];
    assign duty_correction_enable   = duty_cfg;
    assign delay_line_value         = delay;
    assign dll_locked               = locked;
    assign dll_lock_lost            = lost;

endmodule // dll_phase_controller_config
`default_nettype wire

// file: rtl/spi_reg_port.sv
// Serial configuration port: 16-bit frames, read flag, 7-bit address, 8-bit data
`timescale 1ns/1ns
`default_nettype none
module spi_reg_port (
    // Clock and reset
    input  wire logic                               clk,
    input  wire logic                               reset_n,
    // Serial pins, sampled on clk
    input  wire logic                               spi_cs_n,
    input  wire logic                               spi_sclk,
    input  wire logic                               spi_mosi,
    output logic                                    spi_miso,
    output logic                                    spi_miso_oe,
    // Register side
    output logic [dll_cfg_pkg::ADDR_W-1:0]          reg_addr,
    output logic                                    reg_wr,
    output logic [dll_cfg_pkg::DATA_W-1:0]          reg_wdata,
    input  wire logic [dll_cfg_pkg::DATA_W-1:0]     reg_rdata
);

    logic       sclk_q, next_sclk_q;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic [7:0] rx, next_rx;
    logic [7:0] tx, next_tx;
    logic       is_read, next_is_read;
    logic       load, next_load;
    logic       oe, next_oe;
    logic [dll_cfg_pkg::ADDR_W-1:0] addr, next_addr;
    logic       wr, next_wr;
    logic [7:0] wdata, next_wdata;
    logic       rise;
    logic       fall;

    ////////////////////////////////////////////////////////////////////////////
    // Pins are synchronous, so edges come from one registered copy
    always_comb begin
        rise         = spi_sclk && !sclk_q && !spi_cs_n;
        fall         = !spi_sclk && sclk_q && !spi_cs_n;
        next_sclk_q  = spi_sclk;
        next_bit_cnt = bit_cnt;
        next_rx      = rx;
        next_tx      = tx;
        next_is_read = is_read;
        next_load    = 1'b0;
        next_oe      = oe;
        next_addr    = addr;
        next_wr      = 1'b0;
        next_wdata   = wdata;
        if (spi_cs_n) begin
            next_bit_cnt = 5'h00;
            next_oe      = 1'b0;
        end else begin
            if (rise) begin
                next_rx = {rx[6:0], spi_mosi};
                // Extra clocks past one frame are ignored
                if (bit_cnt != dll_cfg_pkg::SPI_FRAME_BITS) begin
                    next_bit_cnt = bit_cnt + 5'h01;
                end
                if (bit_cnt == dll_cfg_pkg::SPI_ADDR_LAST_BIT) begin
                    next_is_read = rx[6];
                    next_addr    = {rx[5:0], spi_mosi};
                    next_load    = 1'b1;
                end
                if (bit_cnt == dll_cfg_pkg::SPI_DATA_LAST_BIT && !is_read) begin
                    next_wr    = 1'b1;
                    next_wdata = {rx[6:0], spi_mosi};
                end
            end
            // Read data is taken one cycle after the address settles
            if (load) begin
                next_tx = reg_rdata;
                next_oe = is_read;
            end else if (fall && bit_cnt > 5'h08) begin
                next_tx = {tx[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sclk_q  <= 1'b0;
            bit_cnt <= 5'h00;
            rx      <= 8'h00;
            tx      <= 8'h00;
            is_read <= 1'b0;
            load    <= 1'b0;
            oe      <= 1'b0;
            addr    <= 7'h00;
            wr      <= 1'b0;
            wdata   <= 8'h00;
        end else begin
            sclk_q  <= next_sclk_q;
            bit_cnt <= next_bit_cnt;
            rx      <= next_rx;
            tx      <= next_tx;
            is_read <= next_is_read;
            load    <= next_load;
            oe      <= next_oe;
            addr    <= next_addr;
            wr      <= next_wr;
            wdata   <= next_wdata;
        end
    end

    assign spi_miso    = tx[7];
    assign spi_miso_oe = oe;
    assign reg_addr    = addr;
    assign reg_wr      = wr;
    assign reg_wdata   = wdata;

endmodule // spi_reg_port
`default_nettype wire

// file: test/dll_cfg_chk.sv
// Port checker for the DLL phase controller block
`timescale 1ns/1ns
`default_nettype none
module dll_cfg_chk (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       spi_cs_n,
    input wire logic       spi_sclk,
    input wire logic       spi_miso,
    input wire logic       spi_miso_oe,
    input wire logic [3:0] pos_offset_magnitude,
    input wire logic       comparator_boost,
    input wire logic       duty_correction_enable,
    input wire logic [8:0] delay_line_value,
    input wire logic       dll_locked,
    input wire logic       dll_lock_lost
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_dmax; delay_line_value <= 9'h1b0; endproperty
    a_dmax: assert property (p_dmax) else $error("delay above limit");
    property p_oe_idle; spi_cs_n && $past(spi_cs_n) |-> !spi_miso_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("miso driven outside frame");
    property p_oe_frame; $rose(spi_miso_oe) |-> !spi_cs_n; endproperty
    a_oe_frame: assert property (p_oe_frame) else $error("miso enabled without select");
    property p_miso_hold; (spi_miso_oe && spi_sclk) [*2] |-> $stable(spi_miso); endproperty
    a_miso_hold: assert property (p_miso_hold) else $error("miso moved in high phase");
    // Writes land two clocks after the last rise, so four idle clocks are safe
    property p_regs; spi_cs_n [*4] |-> $stable({pos_offset_magnitude, comparator_boost, duty_correction_enable}); endproperty
    a_regs: assert property (p_regs) else $error("settings moved without a write");
    property p_lost; $rose(dll_lock_lost) |-> !dll_locked; endproperty
    a_lost: assert property (p_lost) else $error("lost while locked");
    property p_sticky; spi_cs_n [*4] |-> !$fell(dll_lock_lost); endproperty
    a_sticky: assert property (p_sticky) else $error("lost cleared without a write");
    property p_rst; disable iff (1'b0) (!reset_n) [*2] |-> {delay_line_value, dll_locked, dll_lock_lost} == 11'h000; endproperty
    a_rst: assert property (p_rst) else $error("outputs busy in reset");
    c_lock: cover property ($rose(dll_locked));
    c_lost: cover property ($rose(dll_lock_lost));
    c_read: cover property ($rose(spi_miso_oe));
endmodule // dll_cfg_chk
bind dll_phase_controller_config dll_cfg_chk i_chk (.clk, .reset_n, .spi_cs_n, .spi_sclk, .spi_miso, .spi_miso_oe,
    .pos_offset_magnitude, .comparator_boost, .duty_correction_enable, .delay_line_value, .dll_locked, .dll_lock_lost);
`default_nettype wire

// file: test/dll_phase_controller_config_tb.sv
// Random and directed bench for the DLL phase controller block
`timescale 1ns/1ns
`default_nettype none
module dll_phase_controller_config_tb;
    logic       clk = 0, reset_n = 0, cs_n = 1, sclk = 0, mosi = 0, spoil = 0, sp = 0;
    logic       miso, oe, pd, nd, cb, pa, dc, ld, ls;
    logic [3:0] pm, nm;
    logic [7:0] q;
    logic [8:0] mp = 9'h0c8, d, dv;
    int         errors = 0, cmp_count = 0;
    // Detector model: target phase only at the chosen delay
    wire logic [4:0] ph = (dv == mp && !spoil) ? 5'h04 : 5'h14;
    initial forever #4 clk = ~clk;
    dll_phase_controller_config i_dut (.clk, .reset_n, .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe(oe), .phase_measure(ph), .phase_slope_pos(sp), .pos_offset_magnitude(pm),
        .pos_offset_dir(pd), .neg_offset_magnitude(nm), .neg_offset_dir(nd), .comparator_boost(cb),
        .phase_detect_auto_enable(pa), .duty_correction_enable(dc), .delay_line_value(dv), .dll_locked(ld),
        .dll_lock_lost(ls));
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Each sclk high phase spans two clocks and each low phase three, so the port sees every edge
    task automatic xfer(input logic [15:0] f);
        @(posedge clk) cs_n <= 0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk) mosi <= f[i];
            repeat (2) @(posedge clk);
            sclk <= 1;
            if (i < 8) q[i] = miso;
            repeat (2) @(posedge clk);
            sclk <= 0;
        end
        @(posedge clk) cs_n <= 1;
        repeat (3) @(posedge clk);
    endtask
    function automatic logic [8:0] lim(input logic [8:0] v);
        return (v > 9'h1b0) ? 9'h1b0 : v;
    endfunction
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        $display("mismatch at %0t: watchdog expired", $time);
        errors++;
        close_out;
    end
    initial begin
        void'($urandom(32'h0000_022e));
        repeat (8) @(posedge clk);
        reset_n <= 1;
        xfer(16'ha600); chk(q, 8'h42);
        xfer(16'haa00); chk(q, 8'h00);
        xfer(16'hc000); chk(q, 8'h00);
        $display("reset values done");
        for (int k = 0; k < 4; k++) begin
            d = (k == 0) ? 9'h0ff : 9'($urandom);
            xfer({8'h22, d[7:0]}); xfer({8'h23, ~d[7:0]}); xfer({8'h24, d[7:0]}); xfer({8'h25, d[7:0]});
            chk(pm, d[3:0]);
            chk(pd, d[4]);
            chk(nm, 4'(~d[3:0]));
            chk(nd, !d[4]);
            chk({cb, pa}, d[5:4]);
            chk(dc, d[7]);
        end
        $display("clock input settings done");
        xfer(16'h2608);
        for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? 9'h1ff : (k == 1) ? 9'h1b1 : 9'($urandom);
            xfer({8'h27, d[0], 7'h00}); xfer({8'h28, d[8:1]});
            chk(dv, lim(d));
            xfer(16'ha800); chk(q, d[8:1]);
        end
        $display("fixed delay done");
        for (int k = 0; k < 3; k++) begin
            mp <= (k == 1) ? 9'h0e8 : 9'h0c8;
            sp <= (k == 2);
            xfer(16'h2600); xfer({8'h27, 1'b0, 2'(k), 5'h04}); xfer(16'h286c);
            xfer({8'h26, 1'b0, k == 2, 1'b0, k == 1, 4'hb});
            for (int n = 0; n < 600 && ld !== 1'b1; n++) @(posedge clk);
            chk(dv, mp);
            chk(ld, 1'b1);
            xfer(16'ha800); chk(q, mp[8:1]);
            xfer({8'h26, 1'b0, k == 2, 1'b0, k == 1, 4'h3}); xfer(16'ha800); chk(q, 8'h6c);
        end
        $display("search and lock done");
        spoil <= 1;
        for (int n = 0; n < 100 && ls !== 1'b1; n++) @(posedge clk);
        xfer(16'haa00); chk(q, 8'h02);
        xfer(16'h2600); chk(ls, 1'b0);
        // Track only: no search, so the line stays at the start value
        xfer(16'h2623); repeat (20) @(posedge clk);
        chk(ls, 1'b1);
        chk(dv, 9'h0d8);
        $display("lost lock done");
        close_out;
    end
endmodule // dll_phase_controller_config_tb
`default_nettype wire
